// ===== rtl/pmw_params.svh
// constants for picture memory write control
// Operation
// - shift request moves raster toward slave vsync
// - swap commit exchanges inputs, clears raster shift
// - readable flag shows shift in progress
// - flag rises on request, falls at target
// - master freeze stops master memory writes
// - slave freeze stops slave memory writes
// - refresh enable gates periodic memory refresh
// - period select gives 10/7/5.5/4 ms
// - start x is 32*(pos/8)+4*(pos%8)
// - upper five bits block, lower three fine
// - vertical step one line, two in 4:2:0
// - pixels left of fine start get border
// - partial trailing block padded with border
// - left/right border is four times count
// - left border with zero fine fills prior block
// - border written with channel's own colour
// - colour nibble is upper half, low zero
`ifndef PMW_PARAMS_SVH
`define PMW_PARAMS_SVH
// ----------------------------------------------------------------
// sub addresses
// ----------------------------------------------------------------
`define PMW_A_POSY_M 8'h01
`define PMW_A_POSX_M 8'h02
`define PMW_A_LR_M 8'h03
`define PMW_A_Y_M 8'h04
`define PMW_A_UV_M 8'h05
`define PMW_A_UL_M 8'h06
`define PMW_A_POSY_S 8'h23
`define PMW_A_POSX_S 8'h24
`define PMW_A_LR_S 8'h25
`define PMW_A_Y_S 8'h26
`define PMW_A_UV_S 8'h27
`define PMW_A_UL_S 8'h28
`define PMW_A_REFR_PER 8'h53
`define PMW_A_SWAP_REFR 8'h55
`define PMW_A_SHIFT_REQ 8'h56
`define PMW_A_FRZ_S 8'h57
`define PMW_A_FRZ_M 8'h58
`define PMW_A_STATUS 8'h7f
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMW_B_SWAP 0
`define PMW_B_REFR_EN 1
`define PMW_B_LEFT_LSB 0
`define PMW_B_RIGHT_LSB 4
`define PMW_B_UPPER_LSB 0
`define PMW_B_LOWER_LSB 4
`define PMW_B_CB_LSB 0
`define PMW_B_CR_LSB 4
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define PMW_RST_LUMA 4'h1
`define PMW_RST_CHROMA 4'h8
`define PMW_CLK_MHZ 10
`define PMW_REFR_T0_US 10000
`define PMW_REFR_T1_US 7000
`define PMW_REFR_T2_US 5500
`define PMW_REFR_T3_US 4000
`define PMW_PH_W 20
`define PMW_SHIFT_STEP 20'h00400
`define PMW_WORD_W 46
`endif

// ===== rtl/pmw_pkg.sv
// types for picture memory write control
package pmw_pkg;
	typedef enum logic [2:0] {W_IDLE, W_TOP, W_LWAIT, W_LEFT, W_PIC, W_RIGHT, W_BOT} pmw_wst_t;
endpackage

// ===== rtl/pmw_fifo.sv
// small write word fifo with valid/ready on both sides
`timescale 1ns/10ps
module pmw_fifo #(
	parameter int W = 46,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q;
	logic do_w, do_r;

	assign in_ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rp_q];
	assign do_w = in_valid & in_ready;
	assign do_r = out_valid & out_ready;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_w) wp_q <= wp_q + 1'b1;
			if (do_r) rp_q <= rp_q + 1'b1;
			if (do_w && !do_r) cnt_q <= cnt_q + 1'b1;
			else if (do_r && !do_w) cnt_q <= cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (do_w) mem_q[wp_q] <= in_data;
	end
endmodule // pmw_fifo

// ===== rtl/pmw_refresh_timer.sv
// periodic memory refresh tick generator
`timescale 1ns/10ps
module pmw_refresh_timer #(
	parameter int C0 = 100000,
	parameter int C1 = 70000,
	parameter int C2 = 55000,
	parameter int C3 = 40000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic en,
	input wire logic [1:0] sel,
	// one-cycle tick
	output logic tick
);
	logic [19:0] cnt_q, per;

	always_comb begin
		case (sel)
			2'b00: per = 20'(C0 - 1);
			2'b01: per = 20'(C1 - 1);
			2'b10: per = 20'(C2 - 1);
			default: per = 20'(C3 - 1);
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (!en) begin
			cnt_q <= '0;
			tick <= 1'b0;
		end else if (cnt_q >= per) begin
			cnt_q <= '0;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 20'h00001;
			tick <= 1'b0;
		end
	end
endmodule // pmw_refresh_timer

// ===== rtl/pmw_top.sv
// picture memory write control: registers, raster shift, placement
`timescale 1ns/10ps
`include "pmw_params.svh"
module pmw_top #(
	parameter int REFR_CYC0 = `PMW_REFR_T0_US * `PMW_CLK_MHZ,
	parameter int REFR_CYC1 = `PMW_REFR_T1_US * `PMW_CLK_MHZ,
	parameter int REFR_CYC2 = `PMW_REFR_T2_US * `PMW_CLK_MHZ,
	parameter int REFR_CYC3 = `PMW_REFR_T3_US * `PMW_CLK_MHZ,
	parameter int FIFO_DEPTH = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// parameter port behind the serial interface
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// mode
	input wire logic fmt_420,
	// source a
	input wire logic a_fs,
	input wire logic a_fe,
	input wire logic a_valid,
	input wire logic [23:0] a_data,
	input wire logic a_last,
	output logic a_ready,
	// source b
	input wire logic b_fs,
	input wire logic b_fe,
	input wire logic b_valid,
	input wire logic [23:0] b_data,
	input wire logic b_last,
	output logic b_ready,
	// display raster
	output logic disp_vs,
	// picture memory
	output logic mem_valid,
	output logic [`PMW_WORD_W-1:0] mem_word,
	input wire logic mem_ready,
	output logic refresh_req
);
	import pmw_pkg::*;
	localparam int WW = `PMW_WORD_W;
	localparam int PW = `PMW_PH_W;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [10:0] pic_x(input logic [7:0] p);
		pic_x = {1'b0, p, 2'b00};
	endfunction

	function automatic logic [10:0] start_x(input logic [7:0] p, input logic [2:0] lb);
		logic [11:0] t;
		t = {1'b0, pic_x(p)} - {7'h00, lb, 2'b00};
		start_x = t[11] ? 11'h000 : {t[10:5], 5'h00};
	endfunction

	function automatic logic [11:0] ceil_blk(input logic [11:0] v);
		logic [11:0] t;
		t = v + 12'h01f;
		ceil_blk = {t[11:5], 5'h00};
	endfunction

	function automatic logic [9:0] ypix(input logic [7:0] p, input logic f420);
		ypix = f420 ? {1'b0, p, 1'b0} : {2'b00, p};
	endfunction

	function automatic logic [PW-1:0] step_to(input logic [PW-1:0] d, input logic [PW-1:0] t);
		if (d >= t) step_to = t;
		else if (t - d > `PMW_SHIFT_STEP) step_to = d + `PMW_SHIFT_STEP;
		else step_to = t;
	endfunction

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_s1_q, rst_n_q;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// parameter registers
	// ----------------------------------------------------------------
	logic [7:0] hpos_q [2];
	logic [7:0] vpos_q [2];
	logic [2:0] lb_q [2];
	logic [2:0] rb_q [2];
	logic [3:0] ub_q [2];
	logic [3:0] lw_q [2];
	logic [3:0] by_q [2];
	logic [3:0] bu_q [2];
	logic [3:0] bv_q [2];
	logic frz_q [2];
	logic swap_q, refr_en_q, req_q;
	logic [1:0] refr_sel_q;

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int c = 0; c < 2; c++) begin
				hpos_q[c] <= 8'h00;
				vpos_q[c] <= 8'h00;
				lb_q[c] <= 3'h0;
				rb_q[c] <= 3'h0;
				ub_q[c] <= 4'h0;
				lw_q[c] <= 4'h0;
				by_q[c] <= `PMW_RST_LUMA;
				bu_q[c] <= `PMW_RST_CHROMA;
				bv_q[c] <= `PMW_RST_CHROMA;
				frz_q[c] <= 1'b0;
			end
			swap_q <= 1'b0;
			refr_en_q <= 1'b0;
			req_q <= 1'b0;
			refr_sel_q <= 2'b00;
		end else if (reg_wr) begin
			if (reg_addr == `PMW_A_POSY_M) vpos_q[0] <= reg_wdata;
			else if (reg_addr == `PMW_A_POSX_M) hpos_q[0] <= reg_wdata;
			else if (reg_addr == `PMW_A_LR_M) begin
				lb_q[0] <= reg_wdata[`PMW_B_LEFT_LSB +: 3];
				rb_q[0] <= reg_wdata[`PMW_B_RIGHT_LSB +: 3];
			end else if (reg_addr == `PMW_A_Y_M) by_q[0] <= reg_wdata[3:0];
			else if (reg_addr == `PMW_A_UV_M) begin
				bu_q[0] <= reg_wdata[`PMW_B_CB_LSB +: 4];
				bv_q[0] <= reg_wdata[`PMW_B_CR_LSB +: 4];
			end else if (reg_addr == `PMW_A_UL_M) begin
				ub_q[0] <= reg_wdata[`PMW_B_UPPER_LSB +: 4];
				lw_q[0] <= reg_wdata[`PMW_B_LOWER_LSB +: 4];
			end else if (reg_addr == `PMW_A_POSY_S) vpos_q[1] <= reg_wdata;
			else if (reg_addr == `PMW_A_POSX_S) hpos_q[1] <= reg_wdata;
			else if (reg_addr == `PMW_A_LR_S) begin
				lb_q[1] <= reg_wdata[`PMW_B_LEFT_LSB +: 3];
				rb_q[1] <= reg_wdata[`PMW_B_RIGHT_LSB +: 3];
			end else if (reg_addr == `PMW_A_Y_S) by_q[1] <= reg_wdata[3:0];
			else if (reg_addr == `PMW_A_UV_S) begin
				bu_q[1] <= reg_wdata[`PMW_B_CB_LSB +: 4];
				bv_q[1] <= reg_wdata[`PMW_B_CR_LSB +: 4];
			end else if (reg_addr == `PMW_A_UL_S) begin
				ub_q[1] <= reg_wdata[`PMW_B_UPPER_LSB +: 4];
				lw_q[1] <= reg_wdata[`PMW_B_LOWER_LSB +: 4];
			end else if (reg_addr == `PMW_A_REFR_PER) refr_sel_q <= reg_wdata[1:0];
			else if (reg_addr == `PMW_A_SWAP_REFR) begin
				swap_q <= reg_wdata[`PMW_B_SWAP];
				refr_en_q <= reg_wdata[`PMW_B_REFR_EN];
			end else if (reg_addr == `PMW_A_SHIFT_REQ) req_q <= reg_wdata[0];
			else if (reg_addr == `PMW_A_FRZ_S) frz_q[1] <= reg_wdata[0];
			else if (reg_addr == `PMW_A_FRZ_M) frz_q[0] <= reg_wdata[0];
		end
	end

	// ----------------------------------------------------------------
	// source exchange
	// ----------------------------------------------------------------
	logic fs [2], fe [2], pv [2], pl [2], rdy [2];
	logic [23:0] pd [2];
	always_comb begin
		fs[0] = swap_q ? b_fs : a_fs;
		fe[0] = swap_q ? b_fe : a_fe;
		pv[0] = swap_q ? b_valid : a_valid;
		pd[0] = swap_q ? b_data : a_data;
		pl[0] = swap_q ? b_last : a_last;
		fs[1] = swap_q ? a_fs : b_fs;
		fe[1] = swap_q ? a_fe : b_fe;
		pv[1] = swap_q ? a_valid : b_valid;
		pd[1] = swap_q ? a_data : b_data;
		pl[1] = swap_q ? a_last : b_last;
		a_ready = swap_q ? rdy[1] : rdy[0];
		b_ready = swap_q ? rdy[0] : rdy[1];
	end

	// ----------------------------------------------------------------
	// raster phase shift
	// ----------------------------------------------------------------
	logic [PW-1:0] ph_cnt_q, tgt_q, dly_q;
	logic tgt_ok_q, req_d1_q, swap_d1_q, active_q;

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) ph_cnt_q <= '1; // no master field seen yet, no false sync
		else if (fs[0]) ph_cnt_q <= '0;
		else if (ph_cnt_q != '1) ph_cnt_q <= ph_cnt_q + 1'b1;
	end

	// slave vsync position relative to master vsync
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tgt_q <= '0;
			tgt_ok_q <= 1'b0;
		end else if (!req_q) begin
			tgt_ok_q <= 1'b0;
		end else if (fs[1]) begin
			tgt_q <= ph_cnt_q + 1'b1;
			tgt_ok_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dly_q <= '0;
			req_d1_q <= 1'b0;
			swap_d1_q <= 1'b0;
		end else begin
			req_d1_q <= req_q;
			swap_d1_q <= swap_q;
			if (swap_q && !swap_d1_q) dly_q <= '0;
			else if (!req_q) dly_q <= '0;
			else if (fs[0] && tgt_ok_q) dly_q <= step_to(dly_q, tgt_q);
		end
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) active_q <= 1'b0;
		else if (!req_q) active_q <= 1'b0;
		else if (!req_d1_q) active_q <= 1'b1;
		else if (tgt_ok_q && dly_q == tgt_q) active_q <= 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) disp_vs <= 1'b0;
		else disp_vs <= (ph_cnt_q == dly_q);
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) reg_rdata <= 8'h00;
		else if (reg_rd) reg_rdata <= (reg_addr == `PMW_A_STATUS) ? {7'h00, active_q} : 8'h00;
	end

	// ----------------------------------------------------------------
	// field shadows of placement settings
	// ----------------------------------------------------------------
	pmw_wst_t st_q [2];
	logic restart [2];
	logic [7:0] s_hpos_q [2];
	logic [2:0] s_rb_q [2];
	logic [3:0] s_lw_q [2];
	logic [23:0] s_bcol_q [2];
	logic [10:0] sx [2];
	logic [10:0] px [2];

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int c = 0; c < 2; c++) begin
				s_hpos_q[c] <= 8'h00;
				sx[c] <= 11'h000;
				s_rb_q[c] <= 3'h0;
				s_lw_q[c] <= 4'h0;
				s_bcol_q[c] <= {`PMW_RST_LUMA, 4'h0, `PMW_RST_CHROMA, 4'h0, `PMW_RST_CHROMA, 4'h0};
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (restart[c]) begin
					s_hpos_q[c] <= hpos_q[c];
					sx[c] <= start_x(hpos_q[c], lb_q[c]);
					s_rb_q[c] <= rb_q[c];
					s_lw_q[c] <= lw_q[c];
					s_bcol_q[c] <= {by_q[c], 4'h0, bu_q[c], 4'h0, bv_q[c], 4'h0};
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// per-channel block writer
	// ----------------------------------------------------------------
	logic [10:0] x_q [2];
	logic [9:0] y_q [2];
	logic [3:0] ln_q [2];
	logic [10:0] wid_q [2];
	logic [11:0] pend_q [2];
	logic [11:0] lend [2];
	logic [11:0] xn [2];
	logic want [2], go [2];
	logic [WW-1:0] word [2];
	logic push_v, fin_rdy;
	logic [WW-1:0] push_d;

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			px[c] = pic_x(s_hpos_q[c]);
			xn[c] = {1'b0, x_q[c]} + 12'h001;
			lend[c] = ceil_blk({1'b0, px[c]} + {1'b0, wid_q[c]} + {7'h00, s_rb_q[c], 2'b00});
			restart[c] = fs[c] && (st_q[c] == W_IDLE || st_q[c] == W_LWAIT);
			case (st_q[c])
				W_TOP, W_LEFT, W_RIGHT, W_BOT: want[c] = 1'b1;
				W_PIC: want[c] = pv[c];
				default: want[c] = 1'b0;
			endcase
			word[c] = {1'(c), y_q[c], x_q[c], (st_q[c] == W_PIC) ? pd[c] : s_bcol_q[c]};
		end
		// frozen channels advance without writing
		go[0] = frz_q[0] | fin_rdy;
		go[1] = frz_q[1] | (fin_rdy & ~(want[0] & ~frz_q[0]));
		push_v = (want[0] & ~frz_q[0]) | (want[1] & ~frz_q[1]);
		push_d = (want[0] & ~frz_q[0]) ? word[0] : word[1];
		for (int c = 0; c < 2; c++) rdy[c] = (st_q[c] == W_PIC) & go[c];
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int c = 0; c < 2; c++) begin
				st_q[c] <= W_IDLE;
				x_q[c] <= 11'h000;
				y_q[c] <= 10'h000;
				ln_q[c] <= 4'h0;
				wid_q[c] <= 11'h000;
				pend_q[c] <= 12'h000;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (restart[c]) begin
					y_q[c] <= ypix(vpos_q[c], fmt_420) - {6'h00, ub_q[c]};
					x_q[c] <= start_x(hpos_q[c], lb_q[c]);
					ln_q[c] <= ub_q[c];
					st_q[c] <= (ub_q[c] != 4'h0) ? W_TOP : W_LWAIT;
				end else begin
					case (st_q[c])
						W_TOP, W_BOT: if (go[c]) begin
							if (xn[c] >= lend[c]) begin
								x_q[c] <= sx[c];
								y_q[c] <= y_q[c] + 10'h001;
								ln_q[c] <= ln_q[c] - 4'h1;
								if (ln_q[c] == 4'h1) st_q[c] <= (st_q[c] == W_TOP) ? W_LWAIT : W_IDLE;
							end else begin
								x_q[c] <= xn[c][10:0];
							end
						end
						W_LWAIT: if (fe[c]) begin
							x_q[c] <= sx[c];
							ln_q[c] <= s_lw_q[c];
							st_q[c] <= (s_lw_q[c] != 4'h0) ? W_BOT : W_IDLE;
						end else if (pv[c]) begin
							x_q[c] <= sx[c];
							st_q[c] <= (sx[c] == px[c]) ? W_PIC : W_LEFT;
						end
						W_LEFT: if (go[c]) begin
							x_q[c] <= xn[c][10:0];
							if (xn[c][10:0] == px[c]) st_q[c] <= W_PIC;
						end
						W_PIC: if (pv[c] && go[c]) begin
							x_q[c] <= xn[c][10:0];
							if (pl[c]) begin
								pend_q[c] <= xn[c];
								wid_q[c] <= xn[c][10:0] - px[c];
								if (s_rb_q[c] == 3'h0 && xn[c][4:0] == 5'h00) begin
									st_q[c] <= W_LWAIT;
									y_q[c] <= y_q[c] + 10'h001;
								end else begin
									st_q[c] <= W_RIGHT;
								end
							end
						end
						W_RIGHT: if (go[c]) begin
							x_q[c] <= xn[c][10:0];
							if (xn[c] >= pend_q[c] + {7'h00, s_rb_q[c], 2'b00} && xn[c][4:0] == 5'h00) begin
								st_q[c] <= W_LWAIT;
								y_q[c] <= y_q[c] + 10'h001;
							end
						end
						default: st_q[c] <= W_IDLE;
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// write buffer and refresh
	// ----------------------------------------------------------------
	pmw_fifo #(
		.W(WW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(mclk),
		.rst_n(rst_n_q),
		.in_valid(push_v),
		.in_data(push_d),
		.in_ready(fin_rdy),
		.out_valid(mem_valid),
		.out_data(mem_word),
		.out_ready(mem_ready)
	);

	pmw_refresh_timer #(
		.C0(REFR_CYC0),
		.C1(REFR_CYC1),
		.C2(REFR_CYC2),
		.C3(REFR_CYC3)
	) u_refr (
		.clk(mclk),
		.rst_n(rst_n_q),
		.en(refr_en_q),
		.sel(refr_sel_q),
		.tick(refresh_req)
	);
endmodule // pmw_top

// ===== test/pmw_checker.sv
// port checker for memory write control
`timescale 1ns/10ps
`include "pmw_params.svh"
module pmw_checker #(
	parameter int REFR_CYC0 = 100000,
	parameter int REFR_CYC1 = 70000,
	parameter int REFR_CYC2 = 55000,
	parameter int REFR_CYC3 = 40000
) (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// streams and memory
	input wire logic a_fs,
	input wire logic b_fs,
	input wire logic a_ready,
	input wire logic b_ready,
	input wire logic disp_vs,
	input wire logic mem_valid,
	input wire logic [`PMW_WORD_W-1:0] mem_word,
	input wire logic mem_ready,
	input wire logic refresh_req
);
	logic req_q, swap_q, ren_q, mfs;
	logic [1:0] sel_q;
	int cnt_q, per;
	assign mfs = swap_q ? b_fs : a_fs;
	assign per = sel_q[1] ? (sel_q[0] ? REFR_CYC3 : REFR_CYC2) : (sel_q[0] ? REFR_CYC1 : REFR_CYC0);
	// ----
	// shadow of written control bits
	// ----
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			req_q <= 1'b0;
			swap_q <= 1'b0;
			ren_q <= 1'b0;
			sel_q <= 2'h0;
		end else if (reg_wr) begin
			if (reg_addr == 8'h56) req_q <= reg_wdata[0];
			if (reg_addr == 8'h55) swap_q <= reg_wdata[0];
			if (reg_addr == 8'h55) ren_q <= reg_wdata[1];
			if (reg_addr == 8'h53) sel_q <= reg_wdata[1:0];
		end
	end
	// cycles since last refresh with settings unchanged
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) cnt_q <= 0;
		else if (refresh_req || !ren_q || (reg_wr && reg_addr[7:2] == 6'h14)) cnt_q <= 0;
		else cnt_q <= cnt_q + 1;
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	reset_quiet_a: assert property (disable iff (1'b0)
		arst_n && !$past(arst_n) |-> !mem_valid && !a_ready && !b_ready)
		else $error("outputs active at reset release");
	head_hold_a: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_word))
		else $error("memory word changed while stalled");
	refr_pulse_a: assert property (refresh_req |=> !refresh_req)
		else $error("refresh pulse too long");
	refr_off_a: assert property (!ren_q && !$past(ren_q) |-> !refresh_req)
		else $error("refresh while disabled");
	refr_period_a: assert property (ren_q |-> cnt_q <= per)
		else $error("refresh period overrun");
	rdata_zero_a: assert property ($past(reg_rd) && $past(reg_addr) != 8'h7f |-> reg_rdata == 8'h00)
		else $error("nonzero read of write-only place");
	status_bits_a: assert property (reg_rd && reg_addr == 8'h7f |=> reg_rdata[7:1] == 7'h00)
		else $error("status upper bits set");
	vs_follow_a: assert property (!req_q && !$past(req_q) && !$past(req_q, 2)
		|-> disp_vs == $past(mfs, 2))
		else $error("display sync not following master");
	cover property (refresh_req);
	cover property (mem_valid && mem_ready);
	cover property (reg_rd && reg_addr == 8'h7f ##1 reg_rdata[0]);
endmodule // pmw_checker

bind pmw_top pmw_checker #(.REFR_CYC0(REFR_CYC0), .REFR_CYC1(REFR_CYC1),
	.REFR_CYC2(REFR_CYC2), .REFR_CYC3(REFR_CYC3)) u_chk (.mclk, .arst_n, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .a_fs, .b_fs, .a_ready, .b_ready, .disp_vs,
	.mem_valid, .mem_word, .mem_ready, .refresh_req);

// ===== test/pmw_host_model.sv
// host model driving the parameter port
`timescale 1ns/10ps
module pmw_host_model (
	// clock
	mclk,
	// parameter port
	reg_wr,
	reg_rd,
	reg_addr,
	reg_wdata,
	reg_rdata
);
	input wire logic mclk;
	output logic reg_wr;
	output logic reg_rd;
	output logic [7:0] reg_addr;
	output logic [7:0] reg_wdata;
	input wire logic [7:0] reg_rdata;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// one byte per strobe, lines scrambled once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge mclk);
		d = reg_rdata;
	endtask
endmodule // pmw_host_model

// ===== test/pmw_top_tb_top.sv
// self-checking bench for memory write control
`timescale 1ns/10ps
module pmw_top_tb_top;
	localparam int PER[4] = '{40, 30, 20, 10};
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic fmt_420 = 1'b0;
	logic hold = 1'b0;
	logic gen = 1'b0;
	logic mem_ready = 1'b0;
	logic [1:0] fs = 2'h0, fe = 2'h0, vld = 2'h0, lst = 2'h0, rdy, st = 2'h0;
	logic [23:0] dat[2] = '{24'h0, 24'h0};
	logic [23:0] bc[2] = '{24'h108080, 24'h108080};
	logic reg_wr, reg_rd, disp_vs, mem_valid, refresh_req;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic [45:0] mem_word;
	logic [45:0] q[$];
	int n_fail = 0;
	int tests_run = 0;
	int n, k;
	pmw_top #(.REFR_CYC0(PER[0]), .REFR_CYC1(PER[1]), .REFR_CYC2(PER[2]),
		.REFR_CYC3(PER[3])) dut (.mclk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .fmt_420, .a_fs(fs[0]), .a_fe(fe[0]), .a_valid(vld[0]), .a_data(dat[0]),
		.a_last(lst[0]), .a_ready(rdy[0]), .b_fs(fs[1]), .b_fe(fe[1]), .b_valid(vld[1]),
		.b_data(dat[1]), .b_last(lst[1]), .b_ready(rdy[1]), .disp_vs, .mem_valid, .mem_word,
		.mem_ready, .refresh_req);
	pmw_host_model host (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
	initial forever #50 mclk = ~mclk;
	always @(posedge mclk) if (mem_valid && mem_ready) q.push_back(mem_word);
	// memory stalls one cycle in four
	always @(negedge mclk) begin
		st <= st + 2'h1;
		mem_ready <= !hold && st != 2'h3;
	end
	// field syncs, slave 300 cycles behind master
	always begin
		@(negedge mclk);
		if (gen) begin
			fs[0] = 1'b1;
			@(negedge mclk) fs[0] = 1'b0;
			repeat (299) @(negedge mclk);
			fs[1] = 1'b1;
			@(negedge mclk) fs[1] = 1'b0;
			repeat (1698) @(negedge mclk);
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: %s got %0h exp %0h", $time, m, g, e);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic field(input int c);
		int w;
		@(negedge mclk) fs[c] = 1'b1;
		@(negedge mclk) fs[c] = 1'b0;
		for (int i = 0; i < 20; i++) begin
			dat[c] = {8'h40 + 8'(i), 16'h1122};
			lst[c] = (i == 19);
			vld[c] = 1'b1;
			w = 0;
			while (rdy[c] !== 1'b1 && w < 500) begin
				@(negedge mclk);
				w++;
			end
			@(negedge mclk);
		end
		vld[c] = 1'b0;
		lst[c] = 1'b0;
		dat[c] = ~dat[c];
		repeat (80) @(negedge mclk);
		fe[c] = 1'b1;
		@(negedge mclk) fe[c] = 1'b0;
		repeat (200) @(negedge mclk);
	endtask
	task automatic blk(input int c, input logic [7:0] hp, lr, input int x0, px, yy);
		int e;
		e = (px + 20 + 4 * lr[6:4] + 31) / 32 * 32;
		host.wr(c ? 8'h24 : 8'h02, hp);
		host.wr(c ? 8'h25 : 8'h03, lr);
		q.delete();
		field(c);
		chk(q.size(), e - x0, "word count");
		if (q.size() > px - x0) begin
			chk(q[0][45], c[0], "channel");
			chk(q[0][44:35], yy, "row");
			chk(q[0][34:24], x0, "first column");
			chk(q[0][23:0], bc[c], "lead fill");
			chk(q[px-x0][34:24], px, "start column");
			chk(q[px-x0][23:0], 24'h401122, "first pixel");
			chk(q[$][34:24], e - 1, "last column");
			chk(q[$][23:0], bc[c], "trail fill");
		end
	endtask
	task automatic waitref(output int m);
		m = 0;
		do begin
			@(negedge mclk);
			m++;
		end while (refresh_req !== 1'b1 && m < 200);
	endtask
	task automatic vsat(input int c);
		do @(posedge mclk); while (fs[c] !== 1'b1);
		@(negedge mclk);
		chk(disp_vs, 1'b0, "raster sync early");
		@(negedge mclk);
		chk(disp_vs, 1'b1, "raster sync");
	endtask
	initial begin
		#6000000;
		n_fail++;
		$display("unexpected at %0t: watchdog expired", $time);
		conclude();
	end
	initial begin
		repeat (20) @(negedge mclk);
		arst_n = 1'b1;
		repeat (3) @(negedge mclk);
		host.wr(8'h99, 8'hff);
		host.rd(8'h99, rv);
		chk(rv, 8'h00, "unmapped");
		host.rd(8'h55, rv);
		chk(rv, 8'h00, "write only");
		host.rd(8'h7f, rv);
		chk(rv, 8'h00, "idle flag");
		$display("test registers done");
		for (int s = 0; s < 4; s++) begin
			host.wr(8'h53, 8'(s));
			host.wr(8'h55, 8'h02);
			waitref(n);
			waitref(n);
			chk(n, PER[s], "refresh period");
			host.wr(8'h55, 8'h00);
		end
		waitref(n);
		chk(n, 200, "refresh off");
		$display("test refresh done");
		host.wr(8'h04, 8'h03);
		host.wr(8'h05, 8'h5a);
		bc[0] = 24'h30a050;
		hold = 1'b1;
		fork
			blk(0, 8'h0c, 8'h00, 32, 48, 0);
			begin
				repeat (40) @(negedge mclk);
				chk(mem_valid & ~rdy[0], 1'b1, "fifo full");
				hold = 1'b0;
			end
		join
		blk(0, 8'h10, 8'h11, 32, 64, 0);
		host.wr(8'h01, 8'h03);
		fmt_420 = 1'b1;
		blk(0, 8'h11, 8'h77, 32, 68, 6);
		host.wr(8'h01, 8'h00);
		fmt_420 = 1'b0;
		blk(1, 8'h0c, 8'h00, 32, 48, 0);
		host.wr(8'h06, 8'h10);
		q.delete();
		field(0);
		chk(q.size(), 192, "lower border words");
		chk(q[$][44:35], 1, "lower border row");
		chk(q[$][23:0], bc[0], "lower border fill");
		host.wr(8'h06, 8'h00);
		$display("test placement done");
		host.wr(8'h58, 8'h01);
		q.delete();
		field(0);
		chk(q.size(), 0, "master frozen");
		host.wr(8'h58, 8'h00);
		host.wr(8'h57, 8'h01);
		field(1);
		chk(q.size(), 0, "slave frozen");
		host.wr(8'h57, 8'h00);
		$display("test freeze done");
		gen = 1'b1;
		repeat (2100) @(negedge mclk);
		host.wr(8'h56, 8'h01);
		host.rd(8'h7f, rv);
		chk(rv, 8'h01, "shift active");
		k = 0;
		do begin
			repeat (200) @(negedge mclk);
			host.rd(8'h7f, rv);
			k++;
		end while (rv[0] && k < 60);
		chk(rv, 8'h00, "shift done");
		vsat(1);
		host.wr(8'h55, 8'h01);
		host.wr(8'h56, 8'h00);
		vsat(1);
		host.wr(8'h55, 8'h00);
		vsat(0);
		$display("test exchange done");
		conclude();
	end
endmodule // pmw_top_tb_top
